// ### ofd_params.svh
// constants for the operand field decoder
`ifndef OFD_PARAMS_SVH
`define OFD_PARAMS_SVH
`define OFD_ADDR_W 16
`define OFD_SHORT_ADDR_W 6
`define OFD_IMM_MOVE_W 7
`define OFD_IMM_LOOP_W 6
`define OFD_MASK_W 8
`define OFD_ACC_W 36
`define OFD_DATA_W 16
`define OFD_ACC_HI_LSB 16
`define OFD_ZERO16 16'h0000
`define OFD_ZERO36 36'h0_0000_0000
`endif

// ### ofd_pkg.sv
// types for the operand field decoder
package ofd_pkg;
   // operand-formation modes
   typedef enum logic [2:0] {
      OFD_ADDR_PERIPH,
      OFD_ADDR_SHORT_ABS,
      OFD_ADDR_LONG_ABS,
      OFD_ADDR_INDIRECT,
      OFD_ADDR_INDEXED
   } ofd_addr_mode_t;
   typedef enum logic [1:0] {
      OFD_IMM_MOVE,
      OFD_IMM_LOOP,
      OFD_IMM_MASK_HIGH,
      OFD_IMM_MASK_LOW
   } ofd_imm_mode_t;
   // extended general select codes: nine data-unit (two of them unsaturated accumulator) and five address-unit codes
   typedef enum logic [3:0] {
      OFD_SEL_ACC_A,
      OFD_SEL_ACC_B,
      OFD_SEL_ACC_A_HI,
      OFD_SEL_ACC_B_HI,
      OFD_SEL_X0,
      OFD_SEL_Y0,
      OFD_SEL_Y1,
      OFD_SEL_PTR0,
      OFD_SEL_PTR1,
      OFD_SEL_PTR2,
      OFD_SEL_PTR3,
      OFD_SEL_INDEX,
      OFD_SEL_ACC_A_RAW,
      OFD_SEL_ACC_B_RAW
   } ofd_reg_sel_t;
endpackage

// ### ofd_regs_if.sv
// register bank links between the decoder and its register bank
`timescale 1ns/1ps
`default_nettype none
interface ofd_regs_if;
   logic [35:0] acc_a;
   logic [35:0] acc_b;
   logic [15:0] data_reg_x_low;
   logic [15:0] data_reg_y_low;
   logic [15:0] data_reg_y_high;
   logic [15:0] address_pointer_regs [4];
   logic [15:0] index_reg;
   logic wr_en;
   logic [3:0] wr_sel;
   logic [35:0] wr_data;
   modport bank (output acc_a, acc_b, data_reg_x_low, data_reg_y_low, data_reg_y_high,
      address_pointer_regs, index_reg, input wr_en, wr_sel, wr_data);
   modport user (input acc_a, acc_b, data_reg_x_low, data_reg_y_low, data_reg_y_high,
      address_pointer_regs, index_reg, output wr_en, wr_sel, wr_data);
endinterface
`default_nettype wire

// ### ofd_reg_bank.sv
// data-unit and address-unit register bank
`timescale 1ns/1ps
`default_nettype none
`include "ofd_params.svh"
module ofd_reg_bank
   import ofd_pkg::*;
(
   input wire logic clk_sys_in, // core clock
   input wire logic arst_n_in, // async reset, active low
   ofd_regs_if.bank regs // register contents and write port
);
   // ****************
   // register storage
   // ****************
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         regs.acc_a <= `OFD_ZERO36;
         regs.acc_b <= `OFD_ZERO36;
         regs.data_reg_x_low <= `OFD_ZERO16;
         regs.data_reg_y_low <= `OFD_ZERO16;
         regs.data_reg_y_high <= `OFD_ZERO16;
         regs.index_reg <= `OFD_ZERO16;
         for (int i = 0; i < 4; i++) begin
            regs.address_pointer_regs[i] <= `OFD_ZERO16;
         end
      end else if (regs.wr_en) begin
         unique case (ofd_reg_sel_t'(regs.wr_sel))
            OFD_SEL_ACC_A, OFD_SEL_ACC_A_RAW: regs.acc_a <= regs.wr_data;
            OFD_SEL_ACC_B, OFD_SEL_ACC_B_RAW: regs.acc_b <= regs.wr_data;
            OFD_SEL_ACC_A_HI: regs.acc_a[35:16] <= regs.wr_data[19:0];
            OFD_SEL_ACC_B_HI: regs.acc_b[35:16] <= regs.wr_data[19:0];
            OFD_SEL_X0: regs.data_reg_x_low <= regs.wr_data[15:0];
            OFD_SEL_Y0: regs.data_reg_y_low <= regs.wr_data[15:0];
            OFD_SEL_Y1: regs.data_reg_y_high <= regs.wr_data[15:0];
            OFD_SEL_PTR0: regs.address_pointer_regs[0] <= regs.wr_data[15:0];
            OFD_SEL_PTR1: regs.address_pointer_regs[1] <= regs.wr_data[15:0];
            OFD_SEL_PTR2: regs.address_pointer_regs[2] <= regs.wr_data[15:0];
            OFD_SEL_PTR3: regs.address_pointer_regs[3] <= regs.wr_data[15:0];
            OFD_SEL_INDEX: regs.index_reg <= regs.wr_data[15:0];
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### ofd_operand_decode.sv
// operand field decoder: address, immediate and register operand formation
`timescale 1ns/1ps
`default_nettype none
`include "ofd_params.svh"
// Notes on behaviour
// - a peripheral short address is the 6-bit field with all upper bits set to one.
// - a short absolute address is the 6-bit field with all upper bits cleared.
// - a long absolute address is the 16-bit extension word taken unchanged.
// - short immediates are 7 bits for immediate moves and 6 bits for loop and repeat.
// - an 8-bit bit-field mask is placed in the upper or the lower byte of the operand.
// - the data unit holds two 36-bit accumulators and three 16-bit data registers.
// - the upper 16-bit word of either accumulator can be selected alone as a source.
// - the wide pointer select decodes four address pointers and the index register into wide_ptr, which drives no output.
// - the narrow pointer select names only the four address pointers.
// - the index register serves as an offset in indexed modes, never as a base.
// - the extended general select covers twelve register codes plus two unsaturated accumulator codes.
// - an unsaturated accumulator store has its own source code, apart from saturated.
module ofd_operand_decode
   import ofd_pkg::*;
(
   input wire logic clk_sys_in, // core clock, 100 MHz
   input wire logic arst_n_in, // async reset, active low
   input wire logic dec_valid_in, // operand fields valid this cycle
   input wire ofd_addr_mode_t addr_mode_in, // address operand form
   input wire logic [5:0] short_addr_field_in, // short address field
   input wire logic [15:0] ext_word_in, // extension word
   input wire logic [2:0] pointer_or_index_select_in, // wide pointer select
   input wire logic [1:0] pointer_only_select_in, // narrow pointer select
   input wire ofd_imm_mode_t imm_mode_in, // immediate operand form
   input wire logic [6:0] short_immediate_field_in, // short immediate field
   input wire logic [7:0] mask_field_in, // bit-field mask byte
   input wire logic [3:0] extended_general_select_in, // source register code
   input wire logic accum_upper_word_select_in, // pick upper accumulator word
   input wire logic accum_sel_b_in, // accumulator choice for upper-word pick
   input wire logic wr_en_in, // write register file
   input wire logic [3:0] wr_sel_in, // write register code
   input wire logic [35:0] wr_data_in, // write data
   output logic out_valid_out, // outputs below are fresh
   output logic [15:0] eff_addr_out, // formed data address
   output logic addr_err_out, // illegal address mode code
   output logic [15:0] imm_out, // formed immediate operand
   output logic [35:0] src_operand_out, // selected source operand
   output logic src_err_out // illegal source code
);
   // ****************
   // register bank
   // ****************
   ofd_regs_if regs ();
   assign regs.wr_en = wr_en_in;
   assign regs.wr_sel = wr_sel_in;
   assign regs.wr_data = wr_data_in;
   ofd_reg_bank u_bank (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .regs(regs)
   );
   // ****************
   // address formation
   // ****************
   logic [15:0] next_addr;
   logic next_addr_err;
   logic [15:0] wide_ptr;
   always_comb begin
      wide_ptr = regs.index_reg;
      if (pointer_or_index_select_in < 3'h4) begin
         wide_ptr = regs.address_pointer_regs[pointer_or_index_select_in[1:0]];
      end
   end
   always_comb begin
      next_addr = `OFD_ZERO16;
      next_addr_err = 1'b0;
      unique case (addr_mode_in)
         OFD_ADDR_PERIPH: next_addr = {{10{1'b1}}, short_addr_field_in};
         OFD_ADDR_SHORT_ABS: next_addr = {{10{1'b0}}, short_addr_field_in};
         OFD_ADDR_LONG_ABS: next_addr = ext_word_in;
         OFD_ADDR_INDIRECT: begin
            next_addr = regs.address_pointer_regs[pointer_only_select_in];
         end
         OFD_ADDR_INDEXED: begin
            // index is only ever an offset onto a pointer base
            next_addr = 16'(regs.address_pointer_regs[pointer_only_select_in]
               + regs.index_reg);
         end
         default: next_addr_err = 1'b1;
      endcase
   end
   // ****************
   // immediate formation
   // ****************
   logic [15:0] next_imm;
   always_comb begin
      next_imm = `OFD_ZERO16;
      unique case (imm_mode_in)
         OFD_IMM_MOVE: next_imm = {{9{short_immediate_field_in[6]}},
            short_immediate_field_in};
         OFD_IMM_LOOP: next_imm = {10'h000, short_immediate_field_in[5:0]};
         OFD_IMM_MASK_HIGH: next_imm = {mask_field_in, 8'h00};
         OFD_IMM_MASK_LOW: next_imm = {8'h00, mask_field_in};
      endcase
   end
   // ****************
   // source operand select
   // ****************
   logic [35:0] next_src;
   logic next_src_err;
   logic [35:0] acc_sel;
   // saturate a 36-bit accumulator into a 16-bit upper word
   function automatic logic [15:0] sat_word(input logic [35:0] acc);
      logic [15:0] res;
      res = acc[31:16];
      if (acc[35:31] != {5{acc[35]}}) begin
         res = acc[35] ? 16'h8000 : 16'h7FFF;
      end
      return res;
   endfunction
   assign acc_sel = accum_sel_b_in ? regs.acc_b : regs.acc_a;
   always_comb begin
      next_src = `OFD_ZERO36;
      next_src_err = 1'b0;
      if (accum_upper_word_select_in) begin
         next_src = {20'h00000, acc_sel[31:16]};
      end else begin
         unique case (extended_general_select_in)
            OFD_SEL_ACC_A: next_src = {20'h00000, sat_word(regs.acc_a)};
            OFD_SEL_ACC_B: next_src = {20'h00000, sat_word(regs.acc_b)};
            OFD_SEL_ACC_A_RAW: next_src = regs.acc_a;
            OFD_SEL_ACC_B_RAW: next_src = regs.acc_b;
            OFD_SEL_ACC_A_HI: next_src = {20'h00000, regs.acc_a[31:16]};
            OFD_SEL_ACC_B_HI: next_src = {20'h00000, regs.acc_b[31:16]};
            OFD_SEL_X0: next_src = {20'h00000, regs.data_reg_x_low};
            OFD_SEL_Y0: next_src = {20'h00000, regs.data_reg_y_low};
            OFD_SEL_Y1: next_src = {20'h00000, regs.data_reg_y_high};
            OFD_SEL_PTR0, OFD_SEL_PTR1, OFD_SEL_PTR2, OFD_SEL_PTR3: begin
               next_src = {20'h00000, regs.address_pointer_regs[extended_general_select_in[1:0]
                  + 2'h1]};
            end
            OFD_SEL_INDEX: next_src = {20'h00000, regs.index_reg};
            default: next_src_err = 1'b1;
         endcase
      end
   end
   // ****************
   // output registers
   // ****************
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         out_valid_out <= 1'b0;
      end else begin
         out_valid_out <= dec_valid_in;
      end
   end
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         eff_addr_out <= `OFD_ZERO16;
         addr_err_out <= 1'b0;
         imm_out <= `OFD_ZERO16;
         src_operand_out <= `OFD_ZERO36;
         src_err_out <= 1'b0;
      end else if (dec_valid_in) begin
         eff_addr_out <= next_addr;
         addr_err_out <= next_addr_err;
         imm_out <= next_imm;
         src_operand_out <= next_src;
         src_err_out <= next_src_err;
      end
   end
   // ****************
   // checks
   // ****************
   default clocking cb_chk @(posedge clk_sys_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence s_req_periph;
      dec_valid_in && addr_mode_in == OFD_ADDR_PERIPH;
   endsequence
   sequence s_req_raw_a;
      dec_valid_in && !accum_upper_word_select_in && !wr_en_in
         && extended_general_select_in == OFD_SEL_ACC_A_RAW;
   endsequence
   chk_periph_one_fill: assert property (
      s_req_periph |=> eff_addr_out == {10'h3FF, $past(short_addr_field_in)})
      else $error("peripheral address not one-filled");
   chk_short_zero_fill: assert property (
      dec_valid_in && addr_mode_in == OFD_ADDR_SHORT_ABS |=> eff_addr_out[15:6] == 10'h000)
      else $error("short address not zero-filled");
   chk_long_abs_pass: assert property (
      dec_valid_in && addr_mode_in == OFD_ADDR_LONG_ABS |=> eff_addr_out == $past(ext_word_in))
      else $error("long address modified");
   chk_loop_imm_width: assert property (
      dec_valid_in && imm_mode_in == OFD_IMM_LOOP |=> imm_out[15:6] == 10'h000)
      else $error("loop immediate wider than six bits");
   chk_move_sign_ext: assert property (
      dec_valid_in && imm_mode_in == OFD_IMM_MOVE
      |=> imm_out[6:0] == $past(short_immediate_field_in) && imm_out[15:7] == {9{imm_out[6]}})
      else $error("move immediate not extended from seven bits");
   chk_mask_byte_place: assert property (
      dec_valid_in && imm_mode_in == OFD_IMM_MASK_HIGH
      |=> imm_out == {$past(mask_field_in), 8'h00})
      else $error("upper mask misplaced");
   chk_mask_low_place: assert property (
      dec_valid_in && imm_mode_in == OFD_IMM_MASK_LOW
      |=> imm_out == {8'h00, $past(mask_field_in)})
      else $error("lower mask misplaced");
   chk_upper_word_src: assert property (
      dec_valid_in && accum_upper_word_select_in && !accum_sel_b_in && !wr_en_in
      |=> src_operand_out[15:0] == regs.acc_a[31:16])
      else $error("upper accumulator word wrong");
   chk_indirect_no_index: assert property (
      dec_valid_in && addr_mode_in == OFD_ADDR_INDIRECT && !wr_en_in
      |=> eff_addr_out == regs.address_pointer_regs[$past(pointer_only_select_in)])
      else $error("indirect base not a pointer");
   chk_indexed_offset: assert property (
      dec_valid_in && addr_mode_in == OFD_ADDR_INDEXED && !wr_en_in
      |=> eff_addr_out == 16'(regs.address_pointer_regs[$past(pointer_only_select_in)]
         + regs.index_reg))
      else $error("indexed address not pointer plus index");
   chk_bad_src_code: assert property (
      dec_valid_in && !accum_upper_word_select_in
      && extended_general_select_in > OFD_SEL_ACC_B_RAW
      |=> src_err_out && src_operand_out == `OFD_ZERO36)
      else $error("illegal source code not refused");
   chk_raw_acc_store: assert property (
      s_req_raw_a |=> src_operand_out == regs.acc_a)
      else $error("unsaturated store code altered value");
   chk_bad_mode_flag: assert property (
      dec_valid_in && addr_mode_in > OFD_ADDR_INDEXED
      |=> addr_err_out && eff_addr_out == `OFD_ZERO16)
      else $error("illegal address form not refused");
   chk_valid_follow: assert property (
      dec_valid_in |=> out_valid_out)
      else $error("result valid did not follow request");
   chk_valid_single: assert property (
      !dec_valid_in |=> !out_valid_out)
      else $error("result valid without request");
endmodule
`default_nettype wire

// ### ofd_fetch_model.sv
// fetch side model that presents operand fields to the decoder
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model
   import ofd_pkg::*;
(
   input wire logic clk_sys_in, // core clock
   output logic dec_valid_out, // fields valid
   output ofd_addr_mode_t addr_mode_out, // address form
   output logic [5:0] short_addr_out, // short address field
   output logic [15:0] ext_word_out, // extension word
   output logic [2:0] wide_sel_out, // wide pointer select
   output logic [1:0] narrow_sel_out, // narrow pointer select
   output ofd_imm_mode_t imm_mode_out, // immediate form
   output logic [6:0] imm_field_out, // short immediate
   output logic [7:0] mask_out, // mask byte
   output logic [3:0] gen_sel_out, // source register code
   output logic upper_sel_out, // upper word pick
   output logic acc_b_out // accumulator choice
);
   initial begin
      dec_valid_out = 1'b0;
      addr_mode_out = OFD_ADDR_PERIPH;
      imm_mode_out = OFD_IMM_MOVE;
      {short_addr_out, ext_word_out, wide_sel_out, narrow_sel_out} = '0;
      {imm_field_out, mask_out, gen_sel_out, upper_sel_out, acc_b_out} = '0;
   end
   // one instruction held for exactly one cycle, short address, extension word and mask scrambled afterwards
   task issue(input logic [2:0] am, input logic [5:0] sa, input logic [15:0] ew,
      input logic [1:0] ns, input logic [1:0] im, input logic [6:0] ifd,
      input logic [7:0] mk, input logic [3:0] gs, input logic up, input logic ab);
      @(posedge clk_sys_in);
      #1;
      addr_mode_out = ofd_addr_mode_t'(am);
      imm_mode_out = ofd_imm_mode_t'(im);
      {short_addr_out, ext_word_out, narrow_sel_out, wide_sel_out} = {sa, ew, ns, 1'b0, ns};
      {imm_field_out, mask_out, gen_sel_out, upper_sel_out, acc_b_out} = {ifd, mk, gs, up, ab};
      dec_valid_out = 1'b1;
      @(posedge clk_sys_in);
      #1;
      dec_valid_out = 1'b0;
      {short_addr_out, ext_word_out, mask_out} = ~{short_addr_out, ext_word_out, mask_out};
   endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ofd_pkg::*;
   logic clk_sys_in, arst_n_in, dec_valid, wr_en_in, upper_sel, acc_b;
   ofd_addr_mode_t addr_mode;
   ofd_imm_mode_t imm_mode;
   logic [5:0] short_addr;
   logic [15:0] ext_word, eff_addr_out, imm_out;
   logic [2:0] wide_sel;
   logic [1:0] narrow_sel;
   logic [6:0] imm_field;
   logic [7:0] mask;
   logic [3:0] gen_sel, wr_sel_in;
   logic [35:0] wr_data_in, src_operand_out;
   logic out_valid_out, addr_err_out, src_err_out;
   int failures = 0, check_count = 0, cycles = 0;
   // ****************************************
   // instances
   // ****************************************
   ofd_fetch_model i_ofd_fetch_model (.clk_sys_in(clk_sys_in), .dec_valid_out(dec_valid),
      .addr_mode_out(addr_mode), .short_addr_out(short_addr), .ext_word_out(ext_word),
      .wide_sel_out(wide_sel), .narrow_sel_out(narrow_sel), .imm_mode_out(imm_mode),
      .imm_field_out(imm_field), .mask_out(mask), .gen_sel_out(gen_sel),
      .upper_sel_out(upper_sel), .acc_b_out(acc_b));
   ofd_operand_decode i_ofd_operand_decode (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
      .dec_valid_in(dec_valid), .addr_mode_in(addr_mode), .short_addr_field_in(short_addr),
      .ext_word_in(ext_word), .pointer_or_index_select_in(wide_sel),
      .pointer_only_select_in(narrow_sel), .imm_mode_in(imm_mode),
      .short_immediate_field_in(imm_field), .mask_field_in(mask),
      .extended_general_select_in(gen_sel), .accum_upper_word_select_in(upper_sel),
      .accum_sel_b_in(acc_b), .wr_en_in(wr_en_in), .wr_sel_in(wr_sel_in),
      .wr_data_in(wr_data_in), .out_valid_out(out_valid_out), .eff_addr_out(eff_addr_out),
      .addr_err_out(addr_err_out), .imm_out(imm_out), .src_operand_out(src_operand_out),
      .src_err_out(src_err_out));
   // ****************************************
   // clock, timeout and shared tasks
   // ****************************************
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         $display("unexpected timeout after %0d cycles", cycles);
         end_of_test();
      end
   end
   task check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task dec(input logic [2:0] am, input logic [5:0] sa, input logic [15:0] ew,
      input logic [1:0] ns, input logic [1:0] im, input logic [6:0] ifd,
      input logic [7:0] mk, input logic [3:0] gs, input logic up, input logic ab);
      i_ofd_fetch_model.issue(am, sa, ew, ns, im, ifd, mk, gs, up, ab);
      check("out_valid", out_valid_out, 36'h1);
      @(posedge clk_sys_in);
      #1;
      check("out_valid_drop", out_valid_out, 36'h0);
   endtask
   task wr(input logic [3:0] sel, input logic [35:0] data);
      @(posedge clk_sys_in);
      #1;
      {wr_en_in, wr_sel_in, wr_data_in} = {1'b1, sel, data};
      @(posedge clk_sys_in);
      #1;
      wr_en_in = 1'b0;
   endtask
   task end_of_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_addr();
      dec(3'h0, 6'h00, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'h4, 1'b0, 1'b0);
      check("periph_addr", eff_addr_out, 36'hFFC0);
      dec(3'h0, 6'h2A, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'h4, 1'b0, 1'b0);
      check("periph_addr", eff_addr_out, 36'hFFEA);
      dec(3'h1, 6'h3F, 16'hFFFF, 2'h0, 2'h0, 7'h0, 8'h0, 4'h4, 1'b0, 1'b0);
      check("short_abs_addr", eff_addr_out, 36'h003F);
      dec(3'h2, 6'h3F, 16'hA5C3, 2'h0, 2'h0, 7'h0, 8'h0, 4'h4, 1'b0, 1'b0);
      check("long_abs_addr", eff_addr_out, 36'hA5C3);
      check("addr_err", addr_err_out, 36'h0);
      $display("test addr done");
   endtask
   task t_imm();
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h45, 8'h9C, 4'h4, 1'b0, 1'b0);
      check("move_imm", imm_out, 36'hFFC5);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h3A, 8'h9C, 4'h4, 1'b0, 1'b0);
      check("move_imm", imm_out, 36'h003A);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h1, 7'h45, 8'h9C, 4'h4, 1'b0, 1'b0);
      check("loop_imm", imm_out, 36'h0005);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h2, 7'h45, 8'h9C, 4'h4, 1'b0, 1'b0);
      check("mask_high", imm_out, 36'h9C00);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h3, 7'h45, 8'h9C, 4'h4, 1'b0, 1'b0);
      check("mask_low", imm_out, 36'h009C);
      $display("test imm done");
   endtask
   task t_regs();
      for (int k = 4; k < 12; k++) begin
         wr(4'(k), 36'h0_0000_A000 | 36'(k));
      end
      wr(4'hC, 36'hF_8000_1234);
      wr(4'hD, 36'h0_5678_9ABC);
      for (int k = 4; k < 12; k++) begin
         dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'(k), 1'b0, 1'b0);
         check("reg_rd", src_operand_out[15:0], 36'hA000 | 36'(k));
      end
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'hC, 1'b0, 1'b0);
      check("acc_a_raw", src_operand_out, 36'hF_8000_1234);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'hD, 1'b0, 1'b0);
      check("acc_b_raw", src_operand_out, 36'h0_5678_9ABC);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'h0, 1'b0, 1'b0);
      check("sat_differs", src_operand_out == 36'hF_8000_1234, 36'h0);
      check("sat_err", src_err_out, 36'h0);
      check("sat_a", src_operand_out, 36'h0_0000_8000);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'hC, 1'b1, 1'b0);
      check("upper_a", src_operand_out[15:0], 36'h8000);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'hC, 1'b1, 1'b1);
      check("upper_b", src_operand_out[15:0], 36'h5678);
      wr(4'hD, 36'h7_1234_0000);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'h1, 1'b0, 1'b0);
      check("sat_b", src_operand_out, 36'h0_0000_7FFF);
      dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'hD, 1'b0, 1'b0);
      check("acc_b_raw", src_operand_out, 36'h7_1234_0000);
      for (int k = 14; k < 16; k++) begin
         dec(3'h1, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'(k), 1'b0, 1'b0);
         check("src_err", src_err_out, 36'h1);
         check("src_zero", src_operand_out, 36'h0);
      end
      $display("test regs done");
   endtask
   task t_ptr();
      for (int j = 0; j < 4; j++) begin
         dec(3'h3, 6'h0, 16'h0, 2'(j), 2'h0, 7'h0, 8'h0, 4'h4, 1'b0, 1'b0);
         check("indirect", eff_addr_out, 36'hA007 + 36'(j));
         dec(3'h4, 6'h0, 16'h0, 2'(j), 2'h0, 7'h0, 8'h0, 4'h4, 1'b0, 1'b0);
         check("indexed", eff_addr_out, 36'(16'(16'hA007 + 16'(j) + 16'hA00B)));
      end
      dec(3'h5, 6'h0, 16'h0, 2'h0, 2'h0, 7'h0, 8'h0, 4'h4, 1'b0, 1'b0);
      check("mode_err", addr_err_out, 36'h1);
      check("mode_zero", eff_addr_out, 36'h0);
      $display("test ptr done");
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      arst_n_in = 1'b0;
      {wr_en_in, wr_sel_in, wr_data_in} = '0;
      repeat (3) @(posedge clk_sys_in);
      #1;
      arst_n_in = 1'b1;
      t_addr();
      t_imm();
      t_regs();
      t_ptr();
      end_of_test();
   end
endmodule
`default_nettype wire
